// file: mpp_pkg.sv
package mpp_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] OFF_P0_OUT = 8'h00;
  localparam logic [7:0] OFF_P0_DIR = 8'h04;
  localparam logic [7:0] OFF_P0_PLU = 8'h08;
  localparam logic [7:0] OFF_P1_OUT = 8'h0c;
  localparam logic [7:0] OFF_P1_DIR = 8'h10;
  localparam logic [7:0] OFF_P1_PLU = 8'h14;
  localparam logic [7:0] OFF_P2_IN = 8'h18;
  localparam logic [7:0] OFF_P2_PLU = 8'h1c;
  localparam logic [7:0] OFF_P6_OUT = 8'h20;
  localparam logic [7:0] OFF_P6_DIR = 8'h24;
  localparam logic [7:0] OFF_P6_PLU = 8'h28;
  localparam logic [7:0] OFF_P7_OUT = 8'h2c;
  localparam logic [7:0] OFF_P7_DIR = 8'h30;
  localparam logic [7:0] OFF_P7_RES = 8'h34;
  localparam logic [7:0] OFF_P8_OUT = 8'h38;
  localparam logic [7:0] OFF_P8_DIR = 8'h3c;
  localparam logic [7:0] OFF_P8_PLU = 8'h40;
  localparam logic [7:0] OFF_PA_IN = 8'h44;
  localparam logic [7:0] OFF_PA_RES = 8'h48;
  localparam logic [7:0] OFF_RST_CTL = 8'h4c;

  // ==========================================================================
  // resistor select field layout for ports 7 and A
  localparam int RES_EN_LSB = 0;
  localparam int RES_DN_LSB = 8;

  // reset-control register fields
  localparam int RST_BIT_POS = 0;
  localparam int RST_GO_POS = 1;

  // ==========================================================================
  // reset values
  localparam logic [3:0] RST_P0_DIR = 4'h0;
  localparam logic [3:0] RST_P0_PLU = 4'h0;
  localparam logic [4:0] RST_P1_OUT = 5'h00;
  localparam logic [4:0] RST_P1_DIR = 5'h01;
  localparam logic [4:0] RST_P1_PLU = 5'h00;
  localparam logic [3:0] RST_P2_PLU = 4'h0;
  localparam logic [7:0] RST_P6_DIR = 8'h00;
  localparam logic [7:0] RST_P6_PLU = 8'h00;
  localparam logic [1:0] RST_P7_DIR = 2'h0;
  localparam logic [1:0] RST_P7_RES = 2'h0;
  localparam logic [7:0] RST_P8_DIR = 8'h00;
  localparam logic [7:0] RST_P8_PLU = 8'h00;
  localparam logic [7:0] RST_PA_RES = 8'h00;

  // ==========================================================================
  // timing: clock stabilisation wait after the reset pin rises
  localparam int CLK_MHZ = 200;
  localparam int STAB_US = 50;
  localparam int STAB_CYC = STAB_US * CLK_MHZ;
  // software reset pulse driven on the pin
  localparam int SWRST_NS = 1000;
  localparam int SWRST_CYC = (SWRST_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================================
  // carrier types
  typedef struct packed {
    logic [3:0] p0;
    logic [4:0] p1;
    logic [3:0] p2;
    logic [7:0] p6;
    logic [1:0] p7;
    logic [7:0] p8;
    logic [7:0] pa;
  } mpp_pins_s;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_WAIT,
    ST_RUN,
    ST_SWRST
  } mpp_rst_e;

  typedef struct packed {
    logic [3:0] p0_out;
    logic [3:0] p0_dir;
    logic [3:0] p0_plu;
    logic [4:0] p1_out;
    logic [4:0] p1_dir;
    logic [4:0] p1_plu;
    logic [3:0] p2_plu;
    logic [7:0] p6_out;
    logic [7:0] p6_dir;
    logic [7:0] p6_plu;
    logic [1:0] p7_out;
    logic [1:0] p7_dir;
    logic [1:0] p7_res_en;
    logic [1:0] p7_res_dn;
    logic [7:0] p8_out;
    logic [7:0] p8_dir;
    logic [7:0] p8_plu;
    logic [7:0] pa_res_en;
    logic [7:0] pa_res_dn;
    logic rst_bit;
    mpp_rst_e rst_st;
    logic [31:0] cnt;
    logic [31:0] prdata;
    mpp_pins_s s1;
    mpp_pins_s s2;
    mpp_pins_s s3;
    mpp_pins_s pin_f;
    logic [2:0] rpin_sync;
  } mpp_state_s;

endpackage

// file: mpp_port.sv
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
// What this block does
// - port 0: four bits, own direction, pull-up
// - port 0 resets to input, no pull-up
// - port 1: five bits, own direction, pull-up
// - port 1 bit0 resets output low
// - port 2: four inputs, pull-ups off at reset
// - reset pin bit open-drain, low on software reset
// - pin low resets; wait clock settle after release
// - port 6: eight bits, reset to input
// - port 7: two bits, up or down resistor
// - port 8: eight LED-capable bits, reset input
// - port A: eight bits, unmixed up or down
module mpp_port #(
  parameter int STAB_CYCLES = mpp_pkg::STAB_CYC,
  parameter int SWRST_CYCLES = mpp_pkg::SWRST_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mpp_pkg::mpp_pins_s pin_in,
  output mpp_pkg::mpp_pins_s pin_out,
  output mpp_pkg::mpp_pins_s pin_oe,
  output mpp_pkg::mpp_pins_s pin_pullup,
  output logic [1:0] p7_pulldown,
  output logic [7:0] pa_pulldown,
  input wire logic external_reset_low_pin_in,
  output logic external_reset_low_pin_out,
  output logic external_reset_low_pin_oe,
  output logic core_reset_n
);

  mpp_pkg::mpp_state_s q;
  mpp_pkg::mpp_state_s next_q;
  logic wr;
  logic rd;
  logic hit;
  logic rpin_hi;
  logic rpin_lo;
  mpp_pkg::mpp_pins_s rdv;

  // ==========================================================================
  // bus decode
  assign wr = psel & penable & pwrite;
  // read data is fetched in the setup phase so it stands in the access phase
  assign rd = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata = q.prdata;

  // a change of the reset pin counts once the second and third stages agree
  assign rpin_hi = q.rpin_sync[1] & q.rpin_sync[2];
  assign rpin_lo = ~q.rpin_sync[1] & ~q.rpin_sync[2];

  // ==========================================================================
  // read value per port: pin level for inputs, latch for outputs
  always_comb begin
    rdv.p0 = (q.p0_dir & q.p0_out) | (~q.p0_dir & q.pin_f.p0);
    rdv.p1 = (q.p1_dir & q.p1_out) | (~q.p1_dir & q.pin_f.p1);
    rdv.p2 = q.pin_f.p2;
    rdv.p6 = (q.p6_dir & q.p6_out) | (~q.p6_dir & q.pin_f.p6);
    rdv.p7 = (q.p7_dir & q.p7_out) | (~q.p7_dir & q.pin_f.p7);
    rdv.p8 = (q.p8_dir & q.p8_out) | (~q.p8_dir & q.pin_f.p8);
    rdv.pa = q.pin_f.pa;
  end

  // ==========================================================================
  // next-state logic
  always_comb begin
    next_q = q;
    // offsets outside the map raise the slave error
    hit = 1'b1;
    // input synchronisers, three stages
    next_q.s1 = pin_in;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    // a pin change counts once the second and third stages agree
    next_q.pin_f = (q.s2 & q.s3) | (q.pin_f & (q.s2 ^ q.s3));
    next_q.rpin_sync = {q.rpin_sync[1:0], external_reset_low_pin_in};
    // unmapped reads return zero
    next_q.prdata = 32'h0000_0000;
    case (paddr)
      // port 0 controls
      mpp_pkg::OFF_P0_OUT: begin
        next_q.prdata = {28'h0, rdv.p0};
        if (wr) begin
          next_q.p0_out = pwdata[3:0];
        end
      end
      mpp_pkg::OFF_P0_DIR: begin
        next_q.prdata = {28'h0, q.p0_dir};
        if (wr) begin
          next_q.p0_dir = pwdata[3:0];
        end
      end
      mpp_pkg::OFF_P0_PLU: begin
        next_q.prdata = {28'h0, q.p0_plu};
        if (wr) begin
          next_q.p0_plu = pwdata[3:0];
        end
      end
      // port 1 controls
      mpp_pkg::OFF_P1_OUT: begin
        next_q.prdata = {27'h0, rdv.p1};
        if (wr) begin
          next_q.p1_out = pwdata[4:0];
        end
      end
      mpp_pkg::OFF_P1_DIR: begin
        next_q.prdata = {27'h0, q.p1_dir};
        if (wr) begin
          next_q.p1_dir = pwdata[4:0];
        end
      end
      mpp_pkg::OFF_P1_PLU: begin
        next_q.prdata = {27'h0, q.p1_plu};
        if (wr) begin
          next_q.p1_plu = pwdata[4:0];
        end
      end
      // port 2 input and pull-ups
      mpp_pkg::OFF_P2_IN: begin
        next_q.prdata = {28'h0, rdv.p2};
      end
      mpp_pkg::OFF_P2_PLU: begin
        next_q.prdata = {28'h0, q.p2_plu};
        if (wr) begin
          next_q.p2_plu = pwdata[3:0];
        end
      end
      // port 6 controls
      mpp_pkg::OFF_P6_OUT: begin
        next_q.prdata = {24'h0, rdv.p6};
        if (wr) begin
          next_q.p6_out = pwdata[7:0];
        end
      end
      mpp_pkg::OFF_P6_DIR: begin
        next_q.prdata = {24'h0, q.p6_dir};
        if (wr) begin
          next_q.p6_dir = pwdata[7:0];
        end
      end
      mpp_pkg::OFF_P6_PLU: begin
        next_q.prdata = {24'h0, q.p6_plu};
        if (wr) begin
          next_q.p6_plu = pwdata[7:0];
        end
      end
      // port 7 controls and resistor select
      mpp_pkg::OFF_P7_OUT: begin
        next_q.prdata = {30'h0, rdv.p7};
        if (wr) begin
          next_q.p7_out = pwdata[1:0];
        end
      end
      mpp_pkg::OFF_P7_DIR: begin
        next_q.prdata = {30'h0, q.p7_dir};
        if (wr) begin
          next_q.p7_dir = pwdata[1:0];
        end
      end
      mpp_pkg::OFF_P7_RES: begin
        next_q.prdata = {22'h0, q.p7_res_dn, 6'h0, q.p7_res_en};
        if (wr) begin
          next_q.p7_res_en = pwdata[mpp_pkg::RES_EN_LSB +: 2];
          next_q.p7_res_dn = pwdata[mpp_pkg::RES_DN_LSB +: 2];
        end
      end
      // port 8 controls
      mpp_pkg::OFF_P8_OUT: begin
        next_q.prdata = {24'h0, rdv.p8};
        if (wr) begin
          next_q.p8_out = pwdata[7:0];
        end
      end
      mpp_pkg::OFF_P8_DIR: begin
        next_q.prdata = {24'h0, q.p8_dir};
        if (wr) begin
          next_q.p8_dir = pwdata[7:0];
        end
      end
      mpp_pkg::OFF_P8_PLU: begin
        next_q.prdata = {24'h0, q.p8_plu};
        if (wr) begin
          next_q.p8_plu = pwdata[7:0];
        end
      end
      // port A input and resistor select
      mpp_pkg::OFF_PA_IN: begin
        next_q.prdata = {24'h0, rdv.pa};
      end
      mpp_pkg::OFF_PA_RES: begin
        next_q.prdata = {16'h0, q.pa_res_dn, q.pa_res_en};
        if (wr) begin
          next_q.pa_res_en = pwdata[mpp_pkg::RES_EN_LSB +: 8];
          next_q.pa_res_dn = pwdata[mpp_pkg::RES_DN_LSB +: 8];
        end
      end
      // reset pin bit and software reset start
      mpp_pkg::OFF_RST_CTL: begin
        next_q.prdata = {30'h0, q.rst_st == mpp_pkg::ST_SWRST, q.rst_bit};
        if (wr) begin
          next_q.rst_bit = pwdata[mpp_pkg::RST_BIT_POS];
        end
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    // read data holds until the next read
    if (!rd) begin
      next_q.prdata = q.prdata;
    end

    // reset sequencer
    case (q.rst_st)
      // held until the pin is seen high
      mpp_pkg::ST_HOLD: begin
        next_q.cnt = 32'h0;
        if (rpin_hi) begin
          next_q.rst_st = mpp_pkg::ST_WAIT;
        end
      end
      // count out the clock settle time
      mpp_pkg::ST_WAIT: begin
        next_q.cnt = q.cnt + 32'h1;
        if (rpin_lo) begin
          next_q.rst_st = mpp_pkg::ST_HOLD;
        end else if (q.cnt >= 32'(STAB_CYCLES - 1)) begin
          next_q.rst_st = mpp_pkg::ST_RUN;
        end
      end
      // running until the pin goes low or software resets
      mpp_pkg::ST_RUN: begin
        next_q.cnt = 32'h0;
        if (rpin_lo) begin
          next_q.rst_st = mpp_pkg::ST_HOLD;
        end else if (wr && paddr == mpp_pkg::OFF_RST_CTL && pwdata[mpp_pkg::RST_GO_POS]
                     && !q.rst_bit) begin
          next_q.rst_st = mpp_pkg::ST_SWRST;
        end
      end
      // pin pulled low for a fixed time
      mpp_pkg::ST_SWRST: begin
        next_q.cnt = q.cnt + 32'h1;
        if (q.cnt >= 32'(SWRST_CYCLES - 1)) begin
          next_q.rst_st = mpp_pkg::ST_HOLD;
        end
      end
      default: begin
        next_q.rst_st = mpp_pkg::ST_HOLD;
      end
    endcase

    // until the core runs the port controls take their reset values
    if (q.rst_st != mpp_pkg::ST_RUN) begin
      next_q.p0_out = 4'h0;
      next_q.p0_dir = mpp_pkg::RST_P0_DIR;
      next_q.p0_plu = mpp_pkg::RST_P0_PLU;
      next_q.p1_out = mpp_pkg::RST_P1_OUT;
      next_q.p1_dir = mpp_pkg::RST_P1_DIR;
      next_q.p1_plu = mpp_pkg::RST_P1_PLU;
      next_q.p2_plu = mpp_pkg::RST_P2_PLU;
      next_q.p6_out = 8'h00;
      next_q.p6_dir = mpp_pkg::RST_P6_DIR;
      next_q.p6_plu = mpp_pkg::RST_P6_PLU;
      next_q.p7_out = 2'h0;
      next_q.p7_dir = mpp_pkg::RST_P7_DIR;
      next_q.p7_res_en = mpp_pkg::RST_P7_RES;
      next_q.p7_res_dn = mpp_pkg::RST_P7_RES;
      next_q.p8_out = 8'h00;
      next_q.p8_dir = mpp_pkg::RST_P8_DIR;
      next_q.p8_plu = mpp_pkg::RST_P8_PLU;
      next_q.pa_res_en = mpp_pkg::RST_PA_RES;
      next_q.pa_res_dn = mpp_pkg::RST_PA_RES;
      next_q.rst_bit = 1'b1;
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // port controls at their reset values, sequencer held
      q <= '0;
      q.p1_dir <= mpp_pkg::RST_P1_DIR;
      q.rst_bit <= 1'b1;
      q.rst_st <= mpp_pkg::ST_HOLD;
      q.rpin_sync <= 3'h0;
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================================
  // pin drivers
  always_comb begin
    pin_out.p0 = q.p0_out;
    pin_out.p1 = q.p1_out;
    pin_out.p2 = 4'h0;
    pin_out.p6 = q.p6_out;
    pin_out.p7 = q.p7_out;
    pin_out.p8 = q.p8_out;
    pin_out.pa = 8'h00;
    pin_oe.p0 = q.p0_dir;
    pin_oe.p1 = q.p1_dir;
    pin_oe.p2 = 4'h0;
    pin_oe.p6 = q.p6_dir;
    pin_oe.p7 = q.p7_dir;
    pin_oe.p8 = q.p8_dir;
    pin_oe.pa = 8'h00;
  end

  // resistors are only applied to bits that are inputs
  always_comb begin
    pin_pullup.p0 = q.p0_plu & ~q.p0_dir;
    pin_pullup.p1 = q.p1_plu & ~q.p1_dir;
    pin_pullup.p2 = q.p2_plu;
    pin_pullup.p6 = q.p6_plu & ~q.p6_dir;
    pin_pullup.p7 = q.p7_res_en & ~q.p7_res_dn & ~q.p7_dir;
    pin_pullup.p8 = q.p8_plu & ~q.p8_dir;
    pin_pullup.pa = q.pa_res_en & ~q.pa_res_dn;
    p7_pulldown = q.p7_res_en & q.p7_res_dn & ~q.p7_dir;
    pa_pulldown = q.pa_res_en & q.pa_res_dn;
  end

  // open-drain reset pin: only pulls low during a software reset
  assign external_reset_low_pin_out = 1'b0;
  assign external_reset_low_pin_oe = (q.rst_st == mpp_pkg::ST_SWRST);
  assign core_reset_n = (q.rst_st == mpp_pkg::ST_RUN);

endmodule

// file: mpp_port_checker.sv
`timescale 1ns/10ps
// ==========================================================
// port block checks
module mpp_port_checker #(
  parameter int STAB_CYCLES = 8,
  parameter int SWRST_CYCLES = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire mpp_pkg::mpp_pins_s pin_out,
  input wire mpp_pkg::mpp_pins_s pin_oe,
  input wire mpp_pkg::mpp_pins_s pin_pullup,
  input wire logic [1:0] p7_pulldown,
  input wire logic [7:0] pa_pulldown,
  input wire logic external_reset_low_pin_in,
  input wire logic external_reset_low_pin_out,
  input wire logic external_reset_low_pin_oe,
  input wire logic core_reset_n
);
  logic [15:0] sw_cnt;
  logic [15:0] hi_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // length of the soft reset pulse and of the high time of the reset pin
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sw_cnt <= 16'h0000;
      hi_cnt <= 16'h0000;
    end else begin
      sw_cnt <= external_reset_low_pin_oe ? sw_cnt + 16'h0001 : 16'h0000;
      hi_cnt <= !external_reset_low_pin_in ? 16'h0000 : hi_cnt + {15'h0000, ~&hi_cnt};
    end
  end
  // bus access and held reset
  sequence s_acc(logic [7:0] a, logic w);
    psel && penable && pwrite == w && paddr == a;
  endsequence
  sequence s_held;
    (!core_reset_n && !external_reset_low_pin_oe)[*3];
  endsequence
  property p_ready;
    psel && penable |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
  property p_unmapped;
    psel && penable && !pwrite && paddr > mpp_pkg::OFF_RST_CTL |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
  property p_rdout;
    s_acc(mpp_pkg::OFF_P8_OUT, 1'b0) |->
      ((prdata[7:0] ^ pin_out.p8) & pin_oe.p8) == 8'h00;
  endproperty
  a_rdout: assert property (p_rdout) else $error("output bit read wrong");
  property p_dir8;
    s_acc(mpp_pkg::OFF_P8_DIR, 1'b1) ##0 core_reset_n |=> pin_oe.p8 == $past(pwdata[7:0]);
  endproperty
  a_dir8: assert property (p_dir8) else $error("direction not applied");
  property p_pull_in;
    (pin_pullup & pin_oe) == '0;
  endproperty
  a_pull_in: assert property (p_pull_in) else $error("pull on output");
  property p_inonly;
    pin_oe.p2 == 4'h0 && pin_oe.pa == 8'h00;
  endproperty
  a_inonly: assert property (p_inonly) else $error("input port driven");
  property p_nomix;
    ((pin_pullup.p7 | pin_oe.p7) & p7_pulldown) == 2'h0 && (pin_pullup.pa & pa_pulldown) == 8'h00;
  endproperty
  a_nomix: assert property (p_nomix) else $error("pull up and down together");
  property p_held;
    s_held |-> pin_oe.p1 == mpp_pkg::RST_P1_DIR && !pin_out.p1[0] && pin_pullup == '0 &&
      {pin_oe.p0, pin_oe.p6, pin_oe.p7, pin_oe.p8, p7_pulldown, pa_pulldown} == 32'h0;
  endproperty
  a_held: assert property (p_held) else $error("reset state wrong");
  property p_odrain;
    external_reset_low_pin_oe |-> !core_reset_n && !external_reset_low_pin_out;
  endproperty
  a_odrain: assert property (p_odrain) else $error("soft reset pin wrong");
  property p_swlen;
    $fell(external_reset_low_pin_oe) |-> sw_cnt == SWRST_CYCLES;
  endproperty
  a_swlen: assert property (p_swlen) else $error("soft reset length");
  property p_pinlow;
    (!external_reset_low_pin_in)[*5] |-> !core_reset_n;
  endproperty
  a_pinlow: assert property (p_pinlow) else $error("pin low ignored");
  property p_stab;
    $rose(core_reset_n) |-> hi_cnt >= STAB_CYCLES && hi_cnt <= STAB_CYCLES + 5;
  endproperty
  a_stab: assert property (p_stab) else $error("settle wait wrong");
endmodule

// file: mpp_board.sv
`timescale 1ns/10ps
// ==========================================================
// board circuitry resolving each pin from all its drivers
module mpp_board (
  input wire logic clk,
  input wire mpp_pkg::mpp_pins_s pin_out,
  input wire mpp_pkg::mpp_pins_s pin_oe,
  input wire mpp_pkg::mpp_pins_s pin_pullup,
  input wire logic [1:0] p7_pulldown,
  input wire logic [7:0] pa_pulldown,
  input wire mpp_pkg::mpp_pins_s drv_val,
  input wire mpp_pkg::mpp_pins_s drv_en,
  input wire logic rpin_oe,
  input wire logic rpin_low,
  output mpp_pkg::mpp_pins_s pin_in,
  output logic rpin_in
);
  mpp_pkg::mpp_pins_s pd;
  mpp_pkg::mpp_pins_s flt;
  logic flip = 1'b0;
  // floating pins wander every cycle
  always @(posedge clk) flip <= ~flip;
  // device drive, then board drive, then pulls, else floating
  always_comb begin
    pd = '0;
    pd.p7 = p7_pulldown;
    pd.pa = pa_pulldown;
    flt = ~(pin_oe | drv_en | pin_pullup | pd);
    pin_in = (pin_oe & pin_out) | (~pin_oe & drv_en & drv_val) |
      (~pin_oe & ~drv_en & pin_pullup) | (flt & {39{flip}});
  end
  // open drain low from device or board switch, else pulled up
  assign rpin_in = !(rpin_oe || rpin_low);
endmodule

// file: mpp_port_tb.sv
`timescale 1ns/10ps
// ==========================================================
// checker beside the port block
bind mpp_port mpp_port_checker #(.STAB_CYCLES(STAB_CYCLES),
  .SWRST_CYCLES(SWRST_CYCLES)) u_chk (.clk(clk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe),
  .pin_pullup(pin_pullup), .p7_pulldown(p7_pulldown), .pa_pulldown(pa_pulldown),
  .external_reset_low_pin_in(external_reset_low_pin_in),
  .external_reset_low_pin_out(external_reset_low_pin_out),
  .external_reset_low_pin_oe(external_reset_low_pin_oe), .core_reset_n(core_reset_n));
// ==========================================================
// port block testbench
module mpp_port_tb;
  localparam int STAB = 8;
  localparam int SWR = 4;
  localparam mpp_pkg::mpp_pins_s RST_OE = '{p1: mpp_pkg::RST_P1_DIR, default: '0};
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic rpin_low = 1'b0;
  mpp_pkg::mpp_pins_s drv_val = '0;
  mpp_pkg::mpp_pins_s drv_en = '0;
  mpp_pkg::mpp_pins_s pin_in, pin_out, pin_oe, pin_pullup;
  logic [31:0] prdata, rd;
  logic [1:0] p7_pulldown;
  logic [7:0] pa_pulldown;
  logic pready, pslverr, err, rpin_in, rpin_out, rpin_oe, core_reset_n;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  mpp_port #(.STAB_CYCLES(STAB), .SWRST_CYCLES(SWR)) dut (.clk(clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .p7_pulldown(p7_pulldown), .pa_pulldown(pa_pulldown),
    .external_reset_low_pin_in(rpin_in), .external_reset_low_pin_out(rpin_out),
    .external_reset_low_pin_oe(rpin_oe), .core_reset_n(core_reset_n));
  mpp_board board (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .p7_pulldown(p7_pulldown), .pa_pulldown(pa_pulldown), .drv_val(drv_val),
    .drv_en(drv_en), .rpin_oe(rpin_oe), .rpin_low(rpin_low), .pin_in(pin_in),
    .rpin_in(rpin_in));
  // clock and hang guard
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      give_verdict();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic wait_run(output int n);
    n = 0;
    while (core_reset_n !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    int n;
    @(posedge clk);
    #1;
    chk({31'h0, pin_oe === RST_OE && !pin_out.p1[0]}, 32'h1, "reset drive");
    chk({18'h0, pin_pullup.p2, p7_pulldown, pa_pulldown}, 32'h0, "reset pulls");
    wait_run(n);
    chk({31'h0, n >= STAB && n <= STAB + 6}, 32'h1, "start wait");
    for (int a = 0; a <= 'h4c; a += 4) begin
      if (!(a inside {0, 'h0c, 'h18, 'h20, 'h2c, 'h38, 'h44})) begin
        apb(1'b0, 8'(a), 32'h0);
        chk(rd, {31'h0, a == 'h10 || a == 'h4c}, "reset value");
      end
    end
    $display("reset test done");
  endtask
  task automatic t_cfg();
    apb(1'b1, mpp_pkg::OFF_P0_DIR, 32'h5);
    apb(1'b1, mpp_pkg::OFF_P0_PLU, 32'hf);
    apb(1'b1, mpp_pkg::OFF_P1_DIR, 32'h12);
    apb(1'b1, mpp_pkg::OFF_P1_PLU, 32'h1f);
    apb(1'b1, mpp_pkg::OFF_P2_PLU, 32'h6);
    apb(1'b1, mpp_pkg::OFF_P6_DIR, 32'ha5);
    apb(1'b1, mpp_pkg::OFF_P6_PLU, 32'hff);
    apb(1'b1, mpp_pkg::OFF_P8_DIR, 32'h3c);
    apb(1'b1, mpp_pkg::OFF_P8_PLU, 32'hff);
    chk({7'h0, pin_oe.p0, pin_oe.p1, pin_oe.p6, pin_oe.p8}, 32'hb2a53c, "dir");
    chk({3'h0, pin_pullup.p0, pin_pullup.p1, pin_pullup.p2, pin_pullup.p6, pin_pullup.p8},
      32'h14d65ac3, "pull-up");
    $display("config test done");
  endtask
  task automatic t_read();
    @(posedge clk);
    drv_en.p6 <= 8'h5a;
    drv_val.p6 <= 8'h42;
    drv_en.p2 <= 4'hf;
    drv_val.p2 <= 4'h9;
    apb(1'b1, mpp_pkg::OFF_P6_OUT, 32'h0f);
    apb(1'b1, mpp_pkg::OFF_P8_OUT, 32'h24);
    repeat (4) @(posedge clk);
    apb(1'b0, mpp_pkg::OFF_P6_OUT, 32'h0);
    chk(rd, 32'h47, "p6 read");
    apb(1'b0, mpp_pkg::OFF_P8_OUT, 32'h0);
    chk(rd, 32'he7, "p8 read");
    chk({24'h0, pin_in.p8}, 32'he7, "led pins");
    apb(1'b0, mpp_pkg::OFF_P2_IN, 32'h0);
    chk(rd, 32'h9, "p2 read");
    $display("read test done");
  endtask
  task automatic t_res();
    logic [7:0] dn;
    apb(1'b1, mpp_pkg::OFF_P7_DIR, 32'h1);
    for (int k = 0; k < 2; k++) begin
      dn = k ? 8'hff : 8'h00;
      apb(1'b1, mpp_pkg::OFF_P7_RES, {16'h0, dn, 8'h03});
      apb(1'b1, mpp_pkg::OFF_PA_RES, {16'h0, dn, 8'hf0});
      chk({12'h0, pin_pullup.p7, p7_pulldown, pin_pullup.pa, pa_pulldown},
        k ? 32'h200f0 : 32'h8f000, "resistors");
    end
    $display("resistor test done");
  endtask
  task automatic t_bad();
    apb(1'b0, 8'h50, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000, "unmapped read");
    apb(1'b1, 8'h50, 32'hffff);
    chk({31'h0, err}, 32'h1, "unmapped write");
    $display("unmapped test done");
  endtask
  task automatic t_swrst();
    int n;
    apb(1'b1, mpp_pkg::OFF_RST_CTL, 32'h0);
    apb(1'b1, mpp_pkg::OFF_RST_CTL, 32'h2);
    for (n = 0; rpin_oe !== 1'b1 && n < 5; n++) begin
      @(posedge clk);
      #1;
    end
    for (n = 0; rpin_oe === 1'b1 && n < 50; n++) begin
      chk({30'h0, core_reset_n, rpin_in}, 32'h0, "soft reset pin");
      @(posedge clk);
      #1;
    end
    chk(n, SWR, "soft reset length");
    wait_run(n);
    chk({31'h0, n >= STAB && n <= STAB + 6}, 32'h1, "restart wait");
    apb(1'b0, mpp_pkg::OFF_P6_DIR, 32'h0);
    chk(rd, 32'h0, "dir cleared");
    $display("soft reset test done");
  endtask
  task automatic t_pinrst();
    int n;
    @(posedge clk);
    rpin_low <= 1'b1;
    repeat (8) @(posedge clk);
    rpin_low <= 1'b0;
    #1;
    chk({31'h0, !core_reset_n && pin_oe === RST_OE}, 32'h1, "pin reset");
    wait_run(n);
    chk({31'h0, n >= STAB && n <= STAB + 6}, 32'h1, "pin release wait");
    $display("pin reset test done");
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_cfg();
    t_read();
    t_res();
    t_bad();
    t_swrst();
    t_pinrst();
    give_verdict();
  end
endmodule
